// File: rtl/rstc_pkg.sv
package rstc_pkg;
   // Clock and RC oscillator tick periods
   localparam int CLK_PERIOD_NS = 50;
   localparam int RC_TICK_NS    = 50;
   // Start timer and watchdog periods
   localparam int DRT_LONG_US     = 18000;
   localparam int DRT_SHORT_US    = 300;
   localparam int WDT_PERIOD_US   = 18000;
   localparam int DRT_LONG_TICKS  = DRT_LONG_US * 1000 / RC_TICK_NS;
   localparam int DRT_SHORT_TICKS = DRT_SHORT_US * 1000 / RC_TICK_NS;
   localparam int WDT_TICKS       = WDT_PERIOD_US * 1000 / RC_TICK_NS;
   // Register indexes; byte address is four times the index
   localparam logic [5:0] IDX_INDIRECT = 6'h00;
   localparam logic [5:0] IDX_TCOUNT   = 6'h01;
   localparam logic [5:0] IDX_PC       = 6'h02;
   localparam logic [5:0] IDX_STATUS   = 6'h03;
   localparam logic [5:0] IDX_POINTER  = 6'h04;
   localparam logic [5:0] IDX_TRIM     = 6'h05;
   localparam logic [5:0] IDX_PORT     = 6'h06;
   localparam logic [5:0] IDX_WORK     = 6'h07;
   localparam logic [5:0] IDX_OPTION   = 6'h08;
   localparam logic [5:0] IDX_DIR      = 6'h09;
   localparam logic [5:0] IDX_CAUSE    = 6'h0a;
   // Reset values
   localparam logic [7:0] PC_RESET      = 8'hff;
   localparam logic [7:0] STATUS_POR    = 8'h18;
   localparam logic [7:0] OPTION_RESET  = 8'hff;
   localparam logic [5:0] DIR_RESET     = 6'h3f;
   localparam logic [7:0] POINTER_POR   = 8'he0;
   localparam logic [2:0] POINTER_TOP   = 3'h7;
   localparam logic [7:0] TRIM_POR      = 8'h70;
   // Status layout
   localparam int         ST_TIMEOUT    = 4;
   localparam int         ST_POWERDOWN  = 3;
   localparam logic [7:0] STATUS_WR_MSK = 8'he7;
   // Upper five status bits per reset kind, upper three for pin reset while running
   localparam logic [4:0] HI_PIN_SLEEP  = 5'h02;
   localparam logic [4:0] HI_WDT_SLEEP  = 5'h00;
   localparam logic [4:0] HI_WDT_RUN    = 5'h01;
   localparam logic [4:0] HI_PIN_WAKE   = 5'h12;
   localparam logic [2:0] HI_PIN_RUN    = 3'h0;

   typedef enum logic [1:0] {
      low_power_crystal_mode, crystal_mode, internal_rc_mode, external_rc_mode
   } rstc_osc_t;

   typedef enum logic [2:0] {
      CAUSE_POR, CAUSE_PIN_RUN, CAUSE_PIN_SLEEP,
      CAUSE_WDT_RUN, CAUSE_WDT_SLEEP, CAUSE_PIN_WAKE
   } rstc_cause_t;

   typedef enum logic [2:0] {
      ST_WAIT_PIN, ST_COUNT, ST_SYNC, ST_RUN, ST_SLEEP
   } rstc_state_t;

   function automatic logic rstc_is_crystal(input logic [1:0] osc);
      return (osc == low_power_crystal_mode) || (osc == crystal_mode);
   endfunction
endpackage

// File: rtl/rstc_ctrl.sv
`timescale 1ns/10ps
// Notes on behaviour
// R1: Six reset causes: power-on, pin run/sleep, watchdog run/sleep, pin-change wake.
// R2: Registers without reset value keep contents through every non-power-on reset.
// R3: Defined reset values load on power-on and on resets during normal operation.
// R4: Pin or watchdog reset in sleep loads no reset values; only status flags and PC change.
// R5: Power-on status upper bits 00011; program counter all ones.
// R6: Pin reset while running clears status bits 7:5, keeps the rest.
// R7: Pin reset in sleep sets upper status bits to 00010.
// R8: Watchdog expiry in sleep clears upper five status bits.
// R9: Watchdog expiry running gives upper bits 00001; every reset loads PC ones.
// R10: Pin-change wake sets bits 7 and 4, clears 6, 5 and 3.
// R11: Any watchdog reset clears the timeout flag.
// R12: Pin enable fuse at 1 gives active-low reset pin; else general I/O.
// R13: Power-up sets the reset latch and clears the start timer.
// R14: Start timer counts once pin is high, then clears the latch.
// R15: Core held in reset while the start timer runs.
// R16: Start timer advances on its own RC oscillator tick.
// R17: Period long after power-on; later short in RC modes, long in crystal.
// R18: Watchdog expiry restarts the start timer only in crystal modes.
// R19: Watchdog counts its own RC ticks, also during sleep.
// R20: Watchdog expiry in run or sleep causes a device reset.
// R21: Watchdog enable fuse at 0 disables the watchdog permanently.
// R22: After reset accumulator upper nibble holds the trim calibration value.
// R23: Sleep sets timeout flag, clears powerdown flag, clears the watchdog.
// R24: Watchdog clear resets the watchdog and sets both flags.
// R25: Watchdog cleared on every wake from sleep.
// R26: Latch release is synchronised to pclk before the core leaves reset.
module rstc_ctrl
   import rstc_pkg::*;
#(
   parameter int DRT_LONG  = DRT_LONG_TICKS,
   parameter int DRT_SHORT = DRT_SHORT_TICKS,
   parameter int WDT_LIMIT = WDT_TICKS
)(
   // Clock and power-on reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Configuration fuses
   input  wire logic        reset_pin_enable_fuse,
   input  wire logic        watchdog_enable_fuse,
   input  wire logic [1:0]  osc_select,
   input  wire logic [3:0]  trim_cal_value,
   // Pin and RC oscillator ticks
   input  wire logic        ext_reset_pin,
   input  wire logic        drt_rc_tick,
   input  wire logic        wdt_rc_tick,
   output logic             general_pin_three,
   // Core side
   input  wire logic        sleep_op,
   input  wire logic        clear_watchdog_op,
   input  wire logic        pin_change_wake,
   output logic             core_reset_n,
   output logic             core_clock_stop,
   output logic      [2:0]  reset_cause
);

   localparam int DW = $clog2(DRT_LONG + 1);
   localparam int WW = $clog2(WDT_LIMIT + 1);

   if (DRT_SHORT < 1 || DRT_LONG < DRT_SHORT || WDT_LIMIT < 2) begin : g_check
      $error("rstc_ctrl: timer counts out of range");
   end

   function automatic logic addr_ok(input logic [7:0] a);
      return (a[1:0] == 2'h0) && (a[7:2] <= IDX_CAUSE);
   endfunction

   // Sequencer state
   rstc_state_t   state, next_state;
   logic [DW-1:0] drt_count, next_drt_count;
   logic          sync1, sync2;
   logic          por_pending, next_por_pending;
   rstc_cause_t   cause, next_cause;
   logic          next_core_reset_n, next_core_clock_stop;

   // Register file
   logic [7:0] tcount, next_tcount;
   logic [7:0] pc, next_pc;
   logic [7:0] status, next_status;
   logic [7:0] pointer, next_pointer;
   logic [7:0] trim, next_trim;
   logic [5:0] port, next_port;
   logic [7:0] work, next_work;
   logic [7:0] option, next_option;
   logic [5:0] direction, next_direction;

   // Watchdog and bus
   logic [WW-1:0] wdt_count, next_wdt_count;
   logic [31:0]   next_prdata;

   // Events
   logic pin_low, running, asleep, core_up, wdt_expire;
   logic ev_pin_run, ev_pin_sleep, ev_wdt_run, ev_wdt_sleep, ev_wake;
   logic any_reset, full_reset, sleep_ok, clear_watchdog_op_ok, release_now, wr;
   logic [DW-1:0] drt_limit;

   assign pin_low      = reset_pin_enable_fuse & ~ext_reset_pin; // R12
   assign general_pin_three = ~reset_pin_enable_fuse & ext_reset_pin; // R12
   assign running      = (state == ST_RUN);
   assign asleep       = (state == ST_SLEEP);
   assign core_up      = running | asleep;
   assign wdt_expire   = watchdog_enable_fuse & core_up & wdt_rc_tick
                         & (wdt_count == WW'(WDT_LIMIT - 1)); // R19 R21
   assign ev_pin_run   = pin_low & running; // R1
   assign ev_pin_sleep = pin_low & asleep; // R1
   assign ev_wdt_run   = ~pin_low & wdt_expire & running; // R1 R20
   assign ev_wdt_sleep = ~pin_low & wdt_expire & asleep; // R1 R20
   assign ev_wake      = ~pin_low & ~wdt_expire & asleep & pin_change_wake; // R1
   assign any_reset    = ev_pin_run | ev_pin_sleep | ev_wdt_run | ev_wdt_sleep | ev_wake;
   assign full_reset   = ev_pin_run | ev_wdt_run | ev_wake; // R3
   assign sleep_ok     = running & sleep_op & ~any_reset;
   assign clear_watchdog_op_ok    = running & clear_watchdog_op & ~any_reset & ~sleep_op;
   assign release_now  = (state == ST_SYNC) & sync2 & ~pin_low;
   assign wr           = psel & penable & pwrite & addr_ok(paddr);
   // Later resets choose the period by oscillator mode
   assign drt_limit    = (por_pending || rstc_is_crystal(osc_select))
                         ? DW'(DRT_LONG - 1) : DW'(DRT_SHORT - 1); // R17

   // Sequencer
   always_comb begin
      next_state       = state;
      next_drt_count   = drt_count;
      next_por_pending = por_pending;
      next_cause       = cause;
      unique case (state)
         ST_WAIT_PIN: begin
            next_drt_count = '0;
            if (!pin_low) begin
               next_state = ST_COUNT; // R14
            end
         end
         ST_COUNT: begin
            if (pin_low) begin
               next_state     = ST_WAIT_PIN;
               next_drt_count = '0;
            end else if (drt_rc_tick) begin // R16
               if (drt_count == drt_limit) begin
                  next_state = ST_SYNC; // R14
               end else begin
                  next_drt_count = drt_count + DW'(1);
               end
            end
         end
         ST_SYNC: begin
            if (pin_low) begin
               next_state = ST_WAIT_PIN;
            end else if (sync2) begin
               next_state       = ST_RUN; // R26
               next_por_pending = 1'b0;
            end
         end
         ST_RUN, ST_SLEEP: begin
            if (ev_pin_run || ev_pin_sleep || ev_wake) begin
               next_state = ST_WAIT_PIN;
            end else if (ev_wdt_run || ev_wdt_sleep) begin
               // RC modes skip the start timer after a watchdog reset
               next_state = rstc_is_crystal(osc_select) ? ST_WAIT_PIN : ST_SYNC; // R18
            end else if (sleep_ok) begin
               next_state = ST_SLEEP;
            end
            if (ev_pin_run) begin
               next_cause = CAUSE_PIN_RUN;
            end else if (ev_pin_sleep) begin
               next_cause = CAUSE_PIN_SLEEP;
            end else if (ev_wdt_run) begin
               next_cause = CAUSE_WDT_RUN;
            end else if (ev_wdt_sleep) begin
               next_cause = CAUSE_WDT_SLEEP;
            end else if (ev_wake) begin
               next_cause = CAUSE_PIN_WAKE;
            end
         end
         default: begin
            next_state = ST_WAIT_PIN;
         end
      endcase
      next_core_reset_n    = (next_state == ST_RUN) || (next_state == ST_SLEEP); // R15
      next_core_clock_stop = (next_state == ST_SLEEP);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state           <= ST_WAIT_PIN; // R13
         drt_count       <= '0; // R13
         sync1           <= 1'b0;
         sync2           <= 1'b0;
         por_pending     <= 1'b1;
         cause           <= CAUSE_POR;
         core_reset_n    <= 1'b0;
         core_clock_stop <= 1'b0;
      end else begin
         state           <= next_state;
         drt_count       <= next_drt_count;
         sync1           <= (state == ST_SYNC); // R26
         sync2           <= sync1;
         por_pending     <= next_por_pending;
         cause           <= next_cause;
         core_reset_n    <= next_core_reset_n;
         core_clock_stop <= next_core_clock_stop;
      end
   end

   assign reset_cause = 3'(cause);

   // Register file; hardware events override a software write
   always_comb begin
      next_tcount    = tcount;
      next_pc        = pc;
      next_status    = status;
      next_pointer   = pointer;
      next_trim      = trim;
      next_port      = port;
      next_work      = work;
      next_option    = option;
      next_direction = direction;
      if (wr) begin
         unique case (paddr[7:2])
            IDX_TCOUNT:  next_tcount = pwdata[7:0];
            IDX_PC:      next_pc = pwdata[7:0];
            IDX_STATUS:  next_status = (status & ~STATUS_WR_MSK)
                                       | (pwdata[7:0] & STATUS_WR_MSK);
            IDX_POINTER: next_pointer = pwdata[7:0];
            IDX_TRIM:    next_trim = pwdata[7:0];
            IDX_PORT:    next_port = pwdata[5:0];
            IDX_WORK:    next_work = pwdata[7:0];
            IDX_OPTION:  next_option = pwdata[7:0];
            IDX_DIR:     next_direction = pwdata[5:0];
            default:     next_tcount = tcount;
         endcase
      end
      if (sleep_ok) begin
         next_status[ST_TIMEOUT]   = 1'b1; // R23
         next_status[ST_POWERDOWN] = 1'b0; // R23
      end
      if (clear_watchdog_op_ok) begin
         next_status[ST_TIMEOUT]   = 1'b1; // R24
         next_status[ST_POWERDOWN] = 1'b1; // R24
      end
      if (any_reset) begin
         next_pc = PC_RESET; // R9
      end
      if (ev_pin_run) begin
         next_status = {HI_PIN_RUN, status[4:0]}; // R6
      end else if (ev_pin_sleep) begin
         next_status = {HI_PIN_SLEEP, status[2:0]}; // R7 R4
      end else if (ev_wdt_sleep) begin
         next_status = {HI_WDT_SLEEP, status[2:0]}; // R8 R11 R4
      end else if (ev_wdt_run) begin
         next_status = {HI_WDT_RUN, status[2:0]}; // R9 R11
      end else if (ev_wake) begin
         next_status = {HI_PIN_WAKE, status[2:0]}; // R10
      end
      // Timer, port and accumulator low bits are kept on purpose
      if (full_reset) begin
         next_option       = OPTION_RESET; // R3
         next_direction    = DIR_RESET; // R3
         next_pointer[7:5] = POINTER_TOP; // R3 R2
      end
      if (release_now) begin
         next_work[7:4] = trim_cal_value; // R22
      end
   end

   // Unreset registers take zero only because an async reset needs a constant
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tcount    <= 8'h00; // R2
         pc        <= PC_RESET; // R5
         status    <= STATUS_POR; // R5
         pointer   <= POINTER_POR;
         trim      <= TRIM_POR;
         port      <= 6'h00; // R2
         work      <= 8'h00;
         option    <= OPTION_RESET; // R3
         direction <= DIR_RESET; // R3
      end else begin
         tcount    <= next_tcount;
         pc        <= next_pc;
         status    <= next_status;
         pointer   <= next_pointer;
         trim      <= next_trim;
         port      <= next_port;
         work      <= next_work;
         option    <= next_option;
         direction <= next_direction;
      end
   end

   // Watchdog
   always_comb begin
      next_wdt_count = wdt_count;
      if (!watchdog_enable_fuse || !core_up) begin
         next_wdt_count = '0; // R21
      end else if (sleep_ok || clear_watchdog_op_ok || wdt_expire || any_reset) begin
         next_wdt_count = '0; // R23 R24 R25
      end else if (wdt_rc_tick) begin
         next_wdt_count = wdt_count + WW'(1); // R19
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_count <= '0;
      end else begin
         wdt_count <= next_wdt_count;
      end
   end

   // APB read data is captured in the setup cycle
   always_comb begin
      next_prdata = prdata;
      if (psel && !penable && !pwrite) begin
         next_prdata = 32'h0000_0000;
         unique case (paddr[7:2])
            IDX_TCOUNT:  next_prdata[7:0] = tcount;
            IDX_PC:      next_prdata[7:0] = pc;
            IDX_STATUS:  next_prdata[7:0] = status;
            IDX_POINTER: next_prdata[7:0] = pointer;
            IDX_TRIM:    next_prdata[7:0] = trim;
            IDX_PORT:    next_prdata[5:0] = port;
            IDX_WORK:    next_prdata[7:0] = work;
            IDX_CAUSE:   next_prdata[3:0] = {por_pending, 3'(cause)};
            default:     next_prdata[7:0] = 8'h00;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else begin
         prdata <= next_prdata;
      end
   end

   assign pready  = psel & penable;
   assign pslverr = psel & penable & ~addr_ok(paddr);

endmodule

// File: tb/rstc_ctrl_monitor.sv
`timescale 1ns/10ps
module rstc_ctrl_monitor
   import rstc_pkg::*;
#(
   parameter int DRT_LONG  = 20,
   parameter int DRT_SHORT = 5,
   parameter int WDT_LIMIT = 30
)(
   // Clock and reset
   input wire logic       pclk,
   input wire logic       presetn,
   // APB
   input wire logic       psel,
   input wire logic       penable,
   input wire logic [7:0] paddr,
   input wire logic       pslverr,
   // Fuses and pin
   input wire logic       reset_pin_enable_fuse,
   input wire logic       watchdog_enable_fuse,
   input wire logic [1:0] osc_select,
   input wire logic       ext_reset_pin,
   input wire logic       general_pin_three,
   // Core side
   input wire logic       pin_change_wake,
   input wire logic       core_reset_n,
   input wire logic       core_clock_stop,
   input wire logic [2:0] reset_cause
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic pin_low;
   int   hold_cnt;
   assign pin_low = reset_pin_enable_fuse && !ext_reset_pin;
   // Counts cycles in reset; ticks can only make the hold longer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) hold_cnt <= 0;
      else hold_cnt <= core_reset_n ? 0 : hold_cnt + 1;
   end
   sequence running;
      core_reset_n && !core_clock_stop;
   endsequence
   sequence quick_release;
      ##[1:8] core_reset_n;
   endsequence
   a_bad_index: assert property (psel && penable
         && (paddr[7:2] > IDX_CAUSE || paddr[1:0] != 2'h0) |-> pslverr)
      else $error("no slave error");
   a_pin_reset: assert property (pin_low |=> !core_reset_n)
      else $error("core not held by pin");
   a_pin_gpio: assert property (general_pin_three == (!reset_pin_enable_fuse && ext_reset_pin))
      else $error("gpio level wrong");
   a_release_late: assert property ($rose(core_reset_n) |-> !$past(pin_low, 1)
         && !$past(pin_low, 2) && !$past(pin_low, 3))
      else $error("release too soon after pin");
   a_hold_long: assert property ($rose(core_reset_n) && !osc_select[1] |-> hold_cnt >= DRT_LONG)
      else $error("crystal hold too short");
   a_cause_pin: assert property (running ##0 pin_low |=> reset_cause == CAUSE_PIN_RUN)
      else $error("pin run cause");
   a_cause_sleep: assert property (core_clock_stop && pin_low |=>
         reset_cause == CAUSE_PIN_SLEEP && !core_clock_stop)
      else $error("pin sleep cause");
   a_wake_reset: assert property (core_clock_stop && pin_change_wake && !pin_low
         && !watchdog_enable_fuse |=> !core_reset_n && reset_cause == CAUSE_PIN_WAKE)
      else $error("wake reset");
   a_wdt_fuse: assert property ($changed(reset_cause)
         && reset_cause inside {CAUSE_WDT_RUN, CAUSE_WDT_SLEEP} |-> $past(watchdog_enable_fuse))
      else $error("watchdog reset while disabled");
   a_rc_short: assert property ($fell(core_reset_n)
         ##0 (reset_cause == CAUSE_WDT_RUN && osc_select[1]) |-> quick_release)
      else $error("rc watchdog hold too long");
endmodule

bind rstc_ctrl rstc_ctrl_monitor #(
   .DRT_LONG(DRT_LONG), .DRT_SHORT(DRT_SHORT), .WDT_LIMIT(WDT_LIMIT)
) u_monitor (
   .pclk, .presetn, .psel, .penable, .paddr, .pslverr, .reset_pin_enable_fuse,
   .watchdog_enable_fuse, .osc_select, .ext_reset_pin, .general_pin_three,
   .pin_change_wake, .core_reset_n, .core_clock_stop, .reset_cause
);

// File: tb/rstc_core_model.sv
`timescale 1ns/10ps
module rstc_core_model (
   // Clock
   input  wire logic pclk,
   // Bench requests
   input  wire logic want_sleep,
   input  wire logic want_clear,
   input  wire logic want_wake,
   // Device state
   input  wire logic core_reset_n,
   input  wire logic core_clock_stop,
   // Drive into the device
   output logic      drt_rc_tick,
   output logic      wdt_rc_tick,
   output logic      sleep_op,
   output logic      clear_watchdog_op,
   output logic      pin_change_wake
);
   initial {drt_rc_tick, wdt_rc_tick, sleep_op, clear_watchdog_op, pin_change_wake} = '0;
   // A held or stopped core executes nothing; wake only while stopped
   always @(posedge pclk) begin
      drt_rc_tick       <= !drt_rc_tick;
      wdt_rc_tick       <= !wdt_rc_tick;
      sleep_op          <= want_sleep && core_reset_n && !core_clock_stop;
      clear_watchdog_op <= want_clear && core_reset_n && !core_clock_stop;
      pin_change_wake   <= want_wake && core_clock_stop;
   end
endmodule

// File: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top
   import rstc_pkg::*;
;
   localparam int LONG  = 20;
   localparam int SHORT = 5;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        reset_pin_enable_fuse, watchdog_enable_fuse, ext_reset_pin, general_pin_three;
   logic [1:0]  osc_select;
   logic [3:0]  trim_cal_value;
   logic        drt_rc_tick, wdt_rc_tick, sleep_op, clear_watchdog_op, pin_change_wake;
   logic        core_reset_n, core_clock_stop, want_sleep, want_clear, want_wake;
   logic [2:0]  reset_cause;
   int          fails = 0;
   int          comparisons = 0;
   int          n;

   rstc_ctrl #(.DRT_LONG(LONG), .DRT_SHORT(SHORT), .WDT_LIMIT(30)) dut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .reset_pin_enable_fuse, .watchdog_enable_fuse, .osc_select, .trim_cal_value,
      .ext_reset_pin, .drt_rc_tick, .wdt_rc_tick, .general_pin_three, .sleep_op,
      .clear_watchdog_op, .pin_change_wake, .core_reset_n, .core_clock_stop, .reset_cause
   );
   rstc_core_model partner (
      .pclk, .want_sleep, .want_clear, .want_wake, .core_reset_n, .core_clock_stop,
      .drt_rc_tick, .wdt_rc_tick, .sleep_op, .clear_watchdog_op, .pin_change_wake
   );

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge pclk);
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int k;
      k = 0;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) chk(0, 1, "apb hang");
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] x,
                     input string m);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q & msk, x, m);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic x_err);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
      chk({31'h0, e}, {31'h0, x_err}, "slave error");
   endtask
   // Bounded wait; leaves the cycle count in n
   task automatic wait_core(input logic lvl, input int lim);
      n = 0;
      while (core_reset_n !== lvl && n < lim) begin
         @(posedge pclk);
         n++;
      end
      if (n >= lim) chk(0, 1, "core wait");
   endtask
   task automatic enter_sleep();
      want_sleep <= 1'b1;
      cyc(1);
      want_sleep <= 1'b0;
      cyc(4);
      chk(core_clock_stop, 1, "sleep");
      rd(8'h0c, 32'h18, 32'h10, "sleep flags");
   endtask
   task automatic t_por();
      cyc(30);
      chk(core_reset_n, 0, "pin low hold");
      ext_reset_pin <= 1'b1;
      wait_core(1'b1, 300);
      chk(n >= 2 * LONG, 1, "por count");
      rd(8'h28, 32'h7, 32'h0, "por cause");
      rd(8'h0c, 32'hf8, 32'h18, "por status");
      rd(8'h08, 32'hff, 32'hff, "por pc");
      rd(8'h1c, 32'hf0, 32'ha0, "trim");
      rd(8'h20, 32'hffffffff, 32'h0, "option");
      wr(8'h2c, 32'h1, 1'b1);
      wr(8'h0d, 32'h1, 1'b1);
   endtask
   task automatic t_pin_run();
      wr(8'h0c, 32'he5, 1'b0);
      wr(8'h04, 32'h5a, 1'b0);
      wr(8'h08, 32'h12, 1'b0);
      wr(8'h10, 32'h05, 1'b0);
      ext_reset_pin <= 1'b0;
      cyc(4);
      ext_reset_pin <= 1'b1;
      wait_core(1'b1, 300);
      chk(n >= 2 * LONG, 1, "crystal count");
      rd(8'h28, 32'h7, 32'h1, "pin cause");
      rd(8'h0c, 32'hff, 32'h1d, "pin status");
      rd(8'h04, 32'hff, 32'h5a, "timer kept");
      rd(8'h08, 32'hff, 32'hff, "pc");
      rd(8'h10, 32'hff, 32'he5, "pointer");
   endtask
   task automatic t_gpio();
      reset_pin_enable_fuse <= 1'b0;
      ext_reset_pin <= 1'b0;
      cyc(8);
      chk(core_reset_n, 1, "pin ignored");
      chk(general_pin_three, 0, "gpio low");
      ext_reset_pin <= 1'b1;
      cyc(2);
      chk(general_pin_three, 1, "gpio high");
      reset_pin_enable_fuse <= 1'b1;
   endtask
   task automatic t_sleep();
      enter_sleep();
      ext_reset_pin <= 1'b0;
      cyc(2);
      ext_reset_pin <= 1'b1;
      wait_core(1'b1, 300);
      rd(8'h28, 32'h7, 32'h2, "sleep cause");
      rd(8'h0c, 32'hff, 32'h15, "sleep status");
      rd(8'h04, 32'hff, 32'h5a, "timer kept");
      enter_sleep();
      want_wake <= 1'b1;
      cyc(1);
      want_wake <= 1'b0;
      wait_core(1'b0, 10);
      wait_core(1'b1, 300);
      rd(8'h28, 32'h7, 32'h5, "wake cause");
      rd(8'h0c, 32'hff, 32'h95, "wake status");
   endtask
   // Ticks come every other cycle, so the short period sits well below the long one
   task automatic t_rc_pin();
      osc_select <= external_rc_mode;
      ext_reset_pin <= 1'b0;
      cyc(4);
      ext_reset_pin <= 1'b1;
      wait_core(1'b1, 300);
      chk(n >= 2 * SHORT && n < 2 * LONG, 1, "rc short count");
      rd(8'h28, 32'h7, 32'h1, "rc pin cause");
      rd(8'h0c, 32'hff, 32'h15, "rc pin status");
      osc_select <= crystal_mode;
   endtask
   task automatic t_wdt();
      watchdog_enable_fuse <= 1'b1;
      repeat (8) begin
         want_clear <= 1'b1;
         cyc(1);
         want_clear <= 1'b0;
         cyc(20);
      end
      chk(core_reset_n, 1, "clears hold off");
      rd(8'h0c, 32'h18, 32'h18, "clear flags");
      osc_select <= internal_rc_mode;
      wait_core(1'b0, 100);
      wait_core(1'b1, 20);
      chk(n <= 8, 1, "rc no timer");
      rd(8'h28, 32'h7, 32'h3, "wdt cause");
      rd(8'h0c, 32'hff, 32'h0d, "wdt status");
      osc_select <= low_power_crystal_mode;
      enter_sleep();
      wait_core(1'b0, 100);
      wait_core(1'b1, 300);
      chk(n >= 2 * LONG, 1, "crystal restart");
      rd(8'h28, 32'h7, 32'h4, "wdt sleep cause");
      rd(8'h0c, 32'hff, 32'h05, "wdt sleep status");
      watchdog_enable_fuse <= 1'b0;
   endtask
   task automatic conclude();
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // Whole run is a few hundred cycles
   initial begin
      cyc(20000);
      chk(0, 1, "timeout");
      conclude();
   end
   initial begin
      {psel, penable, pwrite, want_sleep, want_clear, want_wake} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      presetn = 1'b0;
      reset_pin_enable_fuse = 1'b1;
      watchdog_enable_fuse = 1'b0;
      ext_reset_pin = 1'b0;
      osc_select = crystal_mode;
      trim_cal_value = 4'ha;
      cyc(12);
      presetn <= 1'b1;
      t_por();
      t_pin_run();
      t_gpio();
      t_sleep();
      t_rc_pin();
      t_wdt();
      conclude();
   end
endmodule
